// ===== hw/gpled_top.sv
// general port with led select, change flags and axi4-lite register access
//
// How it works
// - a packet passing address filtering sets the receive match flag
// - pin 1 or pin 0 toggling sets its change flag, only as general input
// - reading the register clears all three flags; summary clear leaves them
// - write with control bit set updates enables, selects and directions
// - write with control bit clear updates only the four output data bits and the stored low half
// - receive match flag interrupts only while its enable is set
// - pin change flags interrupt only while their own enables are set
// - hardware or software reset clears all three interrupt enables
// - select bit set puts link pass led on pin 3, else general pin
// - select bit set puts address match led on pin 2, else general pin
// - select bit set puts activity led on pin 1, else general pin
// - select bit set puts coax attachment select on pin 0, else general
// - control write sets pin directions, one means output, zero input
// - data write drives values only onto pins set as outputs
// - after any reset all four general pins are inputs
// - both edges of input pins 1 and 0 are detected and may interrupt
// - reading the pin field returns live pin levels
// - control, enable and select bits read back as zero
// - coax attachment level on pin 0 follows stored bit 3
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module gpled_top (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  // axi4-lite write address and data
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output var  logic        S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output var  logic        S_AXI_WREADY_OUT,
  // axi4-lite write response
  output var  logic [1:0]  S_AXI_BRESP_OUT,
  output var  logic        S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output var  logic        S_AXI_ARREADY_OUT,
  output var  logic [31:0] S_AXI_RDATA_OUT,
  output var  logic [1:0]  S_AXI_RRESP_OUT,
  output var  logic        S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  // events from the receive and link logic
  input  wire logic        RX_MATCH_IN,
  input  wire logic        LINK_PASS_IN,
  input  wire logic        ACTIVITY_IN,
  // general pins
  input  wire logic [3:0]  GEP_IN,
  output var  logic [3:0]  GEP_OUT,
  output var  logic [3:0]  GEP_OE_OUT,
  // summary interrupt
  output var  logic        GP_IRQ_OUT
);
  import gpled_pkg::*;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  gpled_pin_if pins ();

  gpled_pin_sync u_sync (
    .clk_in  (CLK_IN),
    .rst_in  (SYS_RST_IN),
    .pins_in (GEP_IN),
    .pif     (pins.src)
  );

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic gpled_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr[7:2] == ofs[7:2];
  endfunction : gpled_hit

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  gpled_state_s q;
  gpled_state_s d;
  logic         commit;
  logic         w_gp;
  logic         w_srst;
  logic         r_gp;
  logic         r_srst;
  logic         ctl_wr;
  logic [1:0]   gen_in;

  always_comb begin
    d      = q;
    commit = q.aw_got && q.w_got && !q.bvalid;
    w_gp   = gpled_hit(q.waddr, GPLED_GP_REG_OFS);
    w_srst = gpled_hit(q.waddr, GPLED_SRST_REG_OFS);
    r_gp   = gpled_hit(S_AXI_ARADDR_IN, GPLED_GP_REG_OFS);
    r_srst = gpled_hit(S_AXI_ARADDR_IN, GPLED_SRST_REG_OFS);
    ctl_wr = q.wstrb[3] && q.wdata[GPLED_CWS_BIT];
    gen_in = ~q.dir[1:0] & ~q.sel[1:0];
    d.soft_rst = 1'b0;
    // write channels are taken in either order
    if (S_AXI_AWVALID_IN && q.awready) begin
      d.aw_got = 1'b1;
      d.waddr  = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = S_AXI_WDATA_IN;
      d.wstrb = S_AXI_WSTRB_IN;
    end
    if (q.bvalid && S_AXI_BREADY_IN) begin
      d.bvalid = 1'b0;
    end
    if (commit) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = (w_gp || w_srst) ? GPLED_OKAY : GPLED_SLVERR;
      if (w_gp) begin
        if (q.wstrb[0]) begin
          d.sia[7:0] = q.wdata[7:0];
        end
        if (q.wstrb[1]) begin
          d.sia[15:8] = q.wdata[15:8];
        end
        if (ctl_wr) begin
          d.irq_en = q.wdata[GPLED_EN_LSB +: 3];
          if (q.wstrb[2]) begin
            d.sel = q.wdata[GPLED_SEL_LSB +: 4];
            d.dir = q.wdata[GPLED_PIN_LSB +: 4];
          end
        end else if (q.wstrb[2]) begin
          d.data = q.wdata[GPLED_PIN_LSB +: 4];
        end
      end
      if (w_srst && q.wstrb[0] && q.wdata[GPLED_SRST_BIT]) begin
        d.soft_rst = 1'b1;
      end
    end
    // read side
    if (q.rvalid && S_AXI_RREADY_IN) begin
      d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_IN && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata  = 32'h0000_0000;
      d.rresp  = (r_gp || r_srst) ? GPLED_OKAY : GPLED_SLVERR;
      if (r_gp) begin
        d.rdata[GPLED_RX_FLAG_BIT]     = q.receive_match_flag;
        d.rdata[GPLED_P1_FLAG_BIT]     = q.pin1_change_flag;
        d.rdata[GPLED_P0_FLAG_BIT]     = q.pin0_change_flag;
        d.rdata[GPLED_PIN_LSB +: 4]    = pins.level;
        d.rdata[15:0]                  = q.sia;
        d.receive_match_flag = 1'b0;
        d.pin1_change_flag   = 1'b0;
        d.pin0_change_flag   = 1'b0;
      end
    end
    // sets come after the read clear so a coincident event survives
    if (RX_MATCH_IN) begin
      d.receive_match_flag = 1'b1;
    end
    if (pins.toggled[1] && gen_in[1]) begin
      d.pin1_change_flag = 1'b1;
    end
    if (pins.toggled[0] && gen_in[0]) begin
      d.pin0_change_flag = 1'b1;
    end
    if (q.soft_rst) begin
      d.irq_en = GPLED_EN_RST;
      d.sel    = GPLED_SEL_RST;
      d.dir    = GPLED_DIR_RST;
    end
    // pin drive, registered in the same stage as the controls
    d.pin_out[3] = d.sel[3] ? LINK_PASS_IN : d.data[3];
    d.pin_out[2] = d.sel[2] ? RX_MATCH_IN : d.data[2];
    d.pin_out[1] = d.sel[1] ? ACTIVITY_IN : d.data[1];
    d.pin_out[0] = d.sel[0] ? d.sia[GPLED_COAX_BIT] : d.data[0];
    d.pin_oe     = d.sel | d.dir;
    // summary clears elsewhere never touch the flags held here
    d.irq = |({d.receive_match_flag, d.pin1_change_flag, d.pin0_change_flag}
              & d.irq_en);
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      q <= GPLED_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY_OUT = q.awready;
  assign S_AXI_WREADY_OUT  = q.wready;
  assign S_AXI_BRESP_OUT   = q.bresp;
  assign S_AXI_BVALID_OUT  = q.bvalid;
  assign S_AXI_ARREADY_OUT = q.arready;
  assign S_AXI_RDATA_OUT   = q.rdata;
  assign S_AXI_RRESP_OUT   = q.rresp;
  assign S_AXI_RVALID_OUT  = q.rvalid;
  assign GEP_OUT           = q.pin_out;
  assign GEP_OE_OUT        = q.pin_oe;
  assign GP_IRQ_OUT        = q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  rx_flag_set_a: assert property (RX_MATCH_IN |=> q.receive_match_flag)
    else $error("receive match flag not set");

  pin0_flag_set_a: assert property (
    (pins.toggled[0] && !q.dir[0] && !q.sel[0]) |=> q.pin0_change_flag)
    else $error("pin 0 change flag not set");

  pin1_flag_set_a: assert property (
    (pins.toggled[1] && !q.dir[1] && !q.sel[1]) |=> q.pin1_change_flag)
    else $error("pin 1 change flag not set");

  pin1_out_quiet_a: assert property (
    (q.dir[1] && !q.pin1_change_flag && !q.soft_rst) |=> !q.pin1_change_flag)
    else $error("pin 1 flag set while output");

  pin0_out_quiet_a: assert property (
    (q.dir[0] && !q.pin0_change_flag && !q.soft_rst) |=> !q.pin0_change_flag)
    else $error("pin 0 flag set while output");

  read_clear_a: assert property (
    (S_AXI_ARVALID_IN && q.arready && r_gp && !RX_MATCH_IN && pins.toggled == 2'h0)
    |=> !q.receive_match_flag && !q.pin1_change_flag && !q.pin0_change_flag)
    else $error("flags not cleared by read");

  ctl_write_a: assert property (
    (commit && w_gp && q.wstrb == 4'hF && q.wdata[GPLED_CWS_BIT])
    |=> q.irq_en == $past(q.wdata[26:24]) && q.dir == $past(q.wdata[19:16]))
    else $error("control write not applied");

  data_write_a: assert property (
    (commit && w_gp && q.wstrb == 4'hF && !q.wdata[GPLED_CWS_BIT] && !q.soft_rst)
    |=> $stable(q.dir) && $stable(q.sel) && $stable(q.irq_en)
        && q.data == $past(q.wdata[19:16]))
    else $error("data write changed controls");

  irq_gate_a: assert property (
    (q.irq_en == 3'h0) |-> !GP_IRQ_OUT)
    else $error("interrupt raised while disabled");

  irq_follow_a: assert property (
    (q.receive_match_flag && q.irq_en[2]) |-> GP_IRQ_OUT)
    else $error("enabled flag gave no interrupt");

  pin_irq_gate_a: assert property (
    (!q.receive_match_flag && q.irq_en[1:0] == 2'h0) |-> !GP_IRQ_OUT)
    else $error("pin interrupt raised while disabled");

  pin_irq_follow_a: assert property (
    ((q.pin1_change_flag && q.irq_en[1]) || (q.pin0_change_flag && q.irq_en[0]))
    |-> GP_IRQ_OUT)
    else $error("enabled pin flag gave no interrupt");

  soft_rst_en_a: assert property (q.soft_rst |=> q.irq_en == 3'h0 && q.dir == 4'h0)
    else $error("soft reset left enables or directions");

  pin3_led_a: assert property (
    (d.sel[3]) |=> GEP_OUT[3] == $past(LINK_PASS_IN) && GEP_OE_OUT[3])
    else $error("pin 3 led not driven");

  pin2_led_a: assert property (
    (d.sel[2]) |=> GEP_OUT[2] == $past(RX_MATCH_IN) && GEP_OE_OUT[2])
    else $error("pin 2 led not driven");

  pin1_led_a: assert property (
    (d.sel[1]) |=> GEP_OUT[1] == $past(ACTIVITY_IN) && GEP_OE_OUT[1])
    else $error("pin 1 led not driven");

  pin0_coax_a: assert property (
    (d.sel[0]) |=> GEP_OUT[0] == $past(d.sia[GPLED_COAX_BIT]) && GEP_OE_OUT[0])
    else $error("pin 0 attachment level wrong");

  pin_oe_a: assert property (
    (d.sel == 4'h0) |=> GEP_OE_OUT == $past(d.dir) && GEP_OUT == $past(d.data))
    else $error("general pin drive wrong");

  rd_zero_a: assert property (
    (S_AXI_ARVALID_IN && q.arready && r_gp) |=> S_AXI_RDATA_OUT[27:20] == 8'h00
    && S_AXI_RDATA_OUT[19:16] == $past(pins.level))
    else $error("read field wrong");

  rst_inputs_a: assert property (disable iff (1'b0)
    $past(SYS_RST_IN) |-> GEP_OE_OUT == 4'h0)
    else $error("pins driven after reset");

endmodule : gpled_top

`default_nettype wire

// ===== hw/gpled_pkg.sv
// shared constants and state type for the general port and led select block
package gpled_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] GPLED_GP_REG_OFS    = 8'h78;
  localparam logic [7:0] GPLED_SRST_REG_OFS  = 8'h7C;

  // ----------------------------------------------------------------
  // field positions of general_port_and_sia_misc
  // ----------------------------------------------------------------
  localparam int GPLED_RX_FLAG_BIT  = 30;
  localparam int GPLED_P1_FLAG_BIT  = 29;
  localparam int GPLED_P0_FLAG_BIT  = 28;
  localparam int GPLED_CWS_BIT      = 27;
  localparam int GPLED_EN_LSB       = 24;
  localparam int GPLED_SEL_LSB      = 20;
  localparam int GPLED_PIN_LSB      = 16;
  localparam int GPLED_COAX_BIT     = 3;
  localparam int GPLED_SRST_BIT     = 0;

  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [2:0]  GPLED_EN_RST   = 3'h0;
  localparam logic [3:0]  GPLED_SEL_RST  = 4'h0;
  localparam logic [3:0]  GPLED_DIR_RST  = 4'h0;
  localparam logic [3:0]  GPLED_DATA_RST = 4'h0;
  localparam logic [15:0] GPLED_SIA_RST  = 16'h0000;
  localparam logic [1:0]  GPLED_OKAY     = 2'h0;
  localparam logic [1:0]  GPLED_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // state of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        arready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        receive_match_flag;
    logic        pin1_change_flag;
    logic        pin0_change_flag;
    logic [2:0]  irq_en;
    logic [3:0]  sel;
    logic [3:0]  dir;
    logic [3:0]  data;
    logic [15:0] sia;
    logic        soft_rst;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
    logic        irq;
  } gpled_state_s;

  localparam gpled_state_s GPLED_STATE_RST = '{
    awready: 1'b0, wready: 1'b0, arready: 1'b0, aw_got: 1'b0, w_got: 1'b0,
    waddr: 8'h00, wdata: 32'h0000_0000, wstrb: 4'h0, bvalid: 1'b0,
    bresp: 2'h0, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: 2'h0,
    receive_match_flag: 1'b0, pin1_change_flag: 1'b0, pin0_change_flag: 1'b0,
    irq_en: GPLED_EN_RST, sel: GPLED_SEL_RST, dir: GPLED_DIR_RST,
    data: GPLED_DATA_RST, sia: GPLED_SIA_RST, soft_rst: 1'b0,
    pin_out: 4'h0, pin_oe: 4'h0, irq: 1'b0};

endpackage : gpled_pkg

// ===== hw/gpled_pin_if.sv
// carrier of synchronised pin levels and toggle pulses
`timescale 1ns/10ps
`default_nettype none

interface gpled_pin_if;
  logic [3:0] level;
  logic [1:0] toggled;

  modport src (output level, output toggled);
  modport dst (input level, input toggled);
endinterface : gpled_pin_if

`default_nettype wire

// ===== hw/gpled_pin_sync.sv
// two-flop synchroniser for the general pins and toggle detector for pins 1 and 0
`timescale 1ns/10ps
`default_nettype none

module gpled_pin_sync (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // raw pin levels
  input  wire logic [3:0] pins_in,
  // synchronised view
  gpled_pin_if.src        pif
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [2:0] live;
  } gpled_sync_s;

  gpled_sync_s q;
  gpled_sync_s d;

  always_comb begin
    d    = q;
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.live = {q.live[1:0], 1'b1};
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '{s1: 4'h0, s2: 4'h0, s3: 4'h0, live: 3'h0};
    end else begin
      q <= d;
    end
  end

  // s1 feeds only s2; both edges of pins 1 and 0 are seen
  assign pif.level   = q.s2;
  // reset value of the stages is not the pin level: mask until s3 holds a real sample
  assign pif.toggled = (q.s2[1:0] ^ q.s3[1:0]) & {2{q.live[2]}};
endmodule : gpled_pin_sync

`default_nettype wire

// ===== dv/gpled_board_model.sv
// board side of the general pins: drives each undriven pin from a bench level
`timescale 1ns/10ps
`default_nettype none

module gpled_board_model (
  // drive from the block
  input  wire logic [3:0] out_in,
  input  wire logic [3:0] oe_in,
  // level of the board source on pins the block leaves undriven
  input  wire logic [3:0] ext_in,
  // resolved wire level
  output var  logic [3:0] lvl_out
);
  // a pin the block drives shows the block's value, so its own toggles show up
  assign lvl_out = (oe_in & out_in) | (~oe_in & ext_in);
endmodule : gpled_board_model

`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the general port and led select block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import gpled_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rxm = 1'b0;
  logic        lnk = 1'b0;
  logic        act = 1'b0;
  logic [3:0]  ext = 4'hA;
  logic        awready, wready, bvalid, arready, rvalid, irq, seen;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [3:0]  pin_lvl, pin_out, pin_oe;
  logic [15:0] sia = 16'h0;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;

  initial begin
    forever #25 clk = ~clk;
  end

  // responses are always accepted at once
  gpled_top uut (
    .CLK_IN(clk), .SYS_RST_IN(rst),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(1'b1), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(1'b1),
    .RX_MATCH_IN(rxm), .LINK_PASS_IN(lnk), .ACTIVITY_IN(act),
    .GEP_IN(pin_lvl), .GEP_OUT(pin_out), .GEP_OE_OUT(pin_oe), .GP_IRQ_OUT(irq)
  );

  gpled_board_model board (
    .out_in(pin_out), .oe_in(pin_oe), .ext_in(ext), .lvl_out(pin_lvl)
  );

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      n_errors++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
  endtask : rd

  // expected word: flags, write-only field as zero, live pins, stored low half
  task automatic rchk(input logic [2:0] f, input logic [3:0] p);
    rd(GPLED_GP_REG_OFS);
    chk(d, {1'b0, f, 8'h00, p, sia});
  endtask : rchk

  // pin sync plus flag set takes three edges; five leaves margin
  task automatic tog(input int i);
    ext[i] <= ~ext[i];
    cyc(5);
  endtask : tog

  task automatic pulse;
    rxm <= 1'b1;
    @(posedge clk);
    rxm <= 1'b0;
  endtask : pulse

  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    cyc(5);
    rst <= 1'b0;
    cyc(2);
    chk(pin_oe, 4'h0);
    rchk(3'b000, 4'hA);
    wr(GPLED_GP_REG_OFS, 32'h0F0C_0000);
    chk(r, GPLED_OKAY);
    wr(GPLED_GP_REG_OFS, 32'h00F4_0000);
    cyc(2);
    chk(pin_oe, 4'hC);
    chk(pin_out & pin_oe, 4'h4);
    rchk(3'b000, 4'h6);
    for (int i = 0; i < 2; i++) begin
      repeat (2) begin
        tog(i);
        chk(irq, 1'b1);
        rchk(3'b001 << i, {2'b01, ext[1:0]});
        chk(irq, 1'b0);
      end
    end
    wr(GPLED_GP_REG_OFS, 32'h0F0E_0000);
    wr(GPLED_GP_REG_OFS, 32'h0006_0000);
    cyc(5);
    chk(irq, 1'b0);
    rchk(3'b000, 4'h6);
    wr(GPLED_GP_REG_OFS, 32'h0900_0000);
    pulse();
    cyc(3);
    chk(irq, 1'b0);
    wr(GPLED_GP_REG_OFS, 32'h0C00_0000);
    cyc(2);
    chk(irq, 1'b1);
    rchk(3'b100, 4'hA);
    tog(1);
    chk(irq, 1'b0);
    rchk(3'b010, 4'h8);
    tog(1);
    rchk(3'b010, 4'hA);
    sia = 16'h0008;
    wr(GPLED_GP_REG_OFS, 32'h0FF0_0008);
    lnk <= 1'b1;
    cyc(3);
    chk(pin_oe, 4'hF);
    chk(pin_out, 4'h9);
    lnk <= 1'b0;
    act <= 1'b1;
    cyc(3);
    chk(pin_out, 4'h3);
    pulse();
    seen = 1'b0;
    repeat (3) begin
      @(posedge clk);
      seen |= pin_out[2];
    end
    chk(seen, 1'b1);
    sia = 16'h0000;
    wr(GPLED_GP_REG_OFS, 32'h0000_0000);
    cyc(2);
    chk(pin_out, 4'h2);
    chk(pin_oe, 4'hF);
    rchk(3'b100, 4'h2);
    wr(GPLED_SRST_REG_OFS, 32'h0000_0001);
    cyc(2);
    chk(pin_oe, 4'h0);
    tog(0);
    chk(irq, 1'b0);
    rchk(3'b001, 4'hB);
    wr(8'h40, 32'hFFFF_FFFF);
    chk(r, GPLED_SLVERR);
    rd(8'h40);
    chk(r, GPLED_SLVERR);
    chk(d, 32'h0);
    wr(GPLED_GP_REG_OFS, 32'h0F0F_0000);
    cyc(2);
    chk(pin_oe, 4'hF);
    // second reset in mid-run
    rst <= 1'b1;
    cyc(5);
    rst <= 1'b0;
    cyc(2);
    chk(pin_oe, 4'h0);
    tog(1);
    chk(irq, 1'b0);
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
